/* File: common/fuse_ctl_pkg.sv */
// Notes on behaviour
// - lock limits debug port to bulk erase
// - lock bit is flash_control bit 6
// - level zero ends by reset alone, which clears the lock
// - global erase also clears external RAM
// - lock clears on reset, writes only set
// - lock blocks external code and RAM reads
// - lock protects only with level0 fuse blown
// - blown fuses stay set, never overridden
// - lock refuses page zero page erase
// - lock suppresses writes to page zero
// - level1 fuse disables debug port forever
// - level1 fuse sampled during reset
// - pin level readable at status bit 5
// - first burn step writes arm code
// - second step selects exactly one fuse
// - fuse burns only while burn code held
// - other trigger value stops burning at once
// - processor mass erase needs arm, pattern, debug port
package fuse_ctl_pkg;
   // processor special register space
   localparam logic [7:0]  FLASH_CONTROL_ADDR   = 8'hb2;
   localparam logic [7:0]  ERASE_ADDR           = 8'h94;
   localparam logic [7:0]  PAGE_SELECT_ADDR     = 8'hb7;
   // mapped into the external data space
   localparam logic [15:0] BURN_TRIGGER_ADDR    = 16'hffd1;
   localparam logic [15:0] FUSE_SELECT_ADDR     = 16'hffd2;
   localparam logic [15:0] SECURITY_STATUS_ADDR = 16'hffd7;
   // flash_control fields
   localparam int WRITE_ENABLE_BIT = 0;
   localparam int MASS_ARM_BIT     = 1;
   localparam int LOCK_BIT         = 6;
   // security_status fields
   localparam int LEVEL1_BIT       = 0;
   localparam int LEVEL0_BIT       = 1;
   localparam int PIN_BIT          = 5;
   // write patterns
   localparam logic [7:0] ARM_CODE      = 8'h54;
   localparam logic [7:0] SELECT_LEVEL0 = 8'h81;
   localparam logic [7:0] SELECT_LEVEL1 = 8'h82;
   localparam logic [7:0] BURN_CODE     = 8'ha6;
   localparam logic [7:0] MASS_PATTERN  = 8'haa;
   localparam logic [7:0] PAGE_PATTERN  = 8'h55;
   // flash page is the address from bit 9 up
   localparam int PAGE_LSB   = 9;
   localparam int PAGE_WIDTH = 7;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   typedef enum logic [2:0] {
      DBG_READ,
      DBG_WRITE,
      DBG_CONTROL,
      DBG_PAGE_ERASE,
      DBG_MASS_ERASE
   } dbg_op_type;

   typedef enum logic [1:0] {
      BURN_IDLE,
      BURN_ARMED,
      BURN_PICK0,
      BURN_PICK1
   } burn_state_type;

   typedef struct packed {
      logic        sfr_wr;
      logic        sfr_rd;
      logic [7:0]  sfr_addr;
      logic        x_wr;
      logic        x_rd;
      logic [15:0] x_addr;
      logic [7:0]  wdata;
   } bus_req_type;

   typedef struct packed {
      logic        valid;
      dbg_op_type  op;
      logic [15:0] addr;
   } dbg_req_type;
endpackage

/* File: src/fuse_burn_seq.sv */
`timescale 1ns/100ps
module fuse_burn_seq
   import fuse_ctl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       select_wr,
   input  wire logic       trigger_wr,
   input  wire logic [7:0] wdata,
   input  wire logic       protect_lock_bit_pin,
   output logic            burn_level0_q,
   output logic            burn_level1_q
);
   burn_state_type state_q, state_d;
   logic           burn0_d, burn1_d;

   always_comb begin
      state_d = state_q;
      burn0_d = burn_level0_q;
      burn1_d = burn_level1_q;
      if (select_wr) begin
         burn0_d = 1'b0;
         burn1_d = 1'b0;
         if (wdata == ARM_CODE)
            state_d = BURN_ARMED;
         else if (state_q == BURN_ARMED && wdata == SELECT_LEVEL0)
            state_d = BURN_PICK0;
         else if (state_q == BURN_ARMED && wdata == SELECT_LEVEL1)
            state_d = BURN_PICK1;
         else
            state_d = BURN_IDLE;
      end else if (trigger_wr) begin
         burn0_d = 1'b0;
         burn1_d = 1'b0;
         case (state_q)
            BURN_PICK0: begin
               if (wdata == BURN_CODE)
                  burn0_d = 1'b1;
               else if (burn_level0_q)
                  state_d = BURN_IDLE;
            end
            BURN_PICK1: begin
               // the pin must stay high or the level1 burn is not driven
               if (wdata == BURN_CODE && protect_lock_bit_pin)
                  burn1_d = 1'b1;
               else if (burn_level1_q)
                  state_d = BURN_IDLE;
            end
            default: ;
         endcase
      end
      if (burn_level1_q && !protect_lock_bit_pin)
         burn1_d = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q       <= BURN_IDLE;
         burn_level0_q <= 1'b0;
         burn_level1_q <= 1'b0;
      end else begin
         state_q       <= state_d;
         burn_level0_q <= burn0_d;
         burn_level1_q <= burn1_d;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   property p_burn_stop;
      trigger_wr && !select_wr && wdata != BURN_CODE
         |=> !burn_level0_q && !burn_level1_q;
   endproperty
   a_burn_stop: assert property (p_burn_stop)
      else $error("burn continued after a stop value");

   property p_pin_drop;
      burn_level1_q && !protect_lock_bit_pin |=> !burn_level1_q;
   endproperty
   a_pin_drop: assert property (p_pin_drop)
      else $error("level1 burn went on with pin low");
endmodule

/* File: src/program_security_fuse_control.sv */
`timescale 1ns/100ps
module program_security_fuse_control
   import fuse_ctl_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                reset,
   input  fuse_ctl_pkg::bus_req_type bus,
   input  wire logic                irq_enabled,
   input  wire logic                level0_fuse_raw,
   input  wire logic                level1_fuse_raw,
   input  wire logic                protect_lock_bit_pin,
   input  fuse_ctl_pkg::dbg_req_type dbg,
   output logic [7:0]               rdata_q,
   output logic                     dbg_port_enable_q,
   output logic                     dbg_grant_q,
   output logic                     dbg_refuse_q,
   output logic                     mass_erase_q,
   output logic                     xram_clear_q,
   output logic                     page_erase_q,
   output logic [6:0]               erase_page_q,
   output logic                     flash_wr_q,
   output logic [15:0]              flash_wr_addr_q,
   output logic [7:0]               flash_wr_data_q,
   output logic                     cpu_refuse_q,
   output logic                     burn_level0_q,
   output logic                     burn_level1_q
);
   import fuse_ctl_pkg::*;

   function automatic logic is_page0(input logic [15:0] a);
      is_page0 = (a[PAGE_LSB +: PAGE_WIDTH] == '0);
   endfunction

   // ---------------- register state ----------------
   logic       lock_q, lock_d;
   logic       wr_en_q, wr_en_d;
   logic       mass_arm_q, mass_arm_d;
   logic [7:0] page_sel_q, page_sel_d;
   logic       level0_q, level0_d;
   logic       level1_q, level1_d;
   logic [7:0] rdata_d;
   logic       protect;
   logic       ctl_wr, erase_wr, page_wr, sel_wr, trig_wr;
   logic       x_flash_wr;

   assign ctl_wr   = bus.sfr_wr && bus.sfr_addr == FLASH_CONTROL_ADDR;
   assign erase_wr = bus.sfr_wr && bus.sfr_addr == ERASE_ADDR;
   assign page_wr  = bus.sfr_wr && bus.sfr_addr == PAGE_SELECT_ADDR;
   assign sel_wr   = bus.x_wr && bus.x_addr == FUSE_SELECT_ADDR;
   assign trig_wr  = bus.x_wr && bus.x_addr == BURN_TRIGGER_ADDR;
   // with write enable set, data stores go to flash instead of RAM
   assign x_flash_wr = bus.x_wr && wr_en_q && !sel_wr && !trig_wr
                       && bus.x_addr != SECURITY_STATUS_ADDR;

   // lock without a blown level0 fuse is inert
   assign protect = lock_q && level0_q;

   always_comb begin
      lock_d     = lock_q;
      wr_en_d    = wr_en_q;
      mass_arm_d = mass_arm_q;
      page_sel_d = page_sel_q;
      if (ctl_wr) begin
         // writing zero cannot clear the lock
         lock_d     = lock_q | bus.wdata[LOCK_BIT];
         mass_arm_d = bus.wdata[MASS_ARM_BIT];
         if (!irq_enabled)
            wr_en_d = bus.wdata[WRITE_ENABLE_BIT];
      end
      if (page_wr)
         page_sel_d = bus.wdata;
      // arm is consumed by any mass erase pattern attempt
      if (erase_wr && bus.wdata == MASS_PATTERN)
         mass_arm_d = 1'b0;
      if (x_flash_wr)
         wr_en_d = 1'b0;
   end

   // fuses: caught while reset is held, then only ever set
   always_comb begin
      if (reset) begin
         level0_d = level0_fuse_raw;
         level1_d = level1_fuse_raw;
      end else begin
         level0_d = level0_q | level0_fuse_raw;
         level1_d = level1_q | level1_fuse_raw;
      end
   end

   always_comb begin
      rdata_d = RESET_BYTE;
      if (bus.sfr_rd && bus.sfr_addr == FLASH_CONTROL_ADDR) begin
         rdata_d[LOCK_BIT]         = lock_q;
         rdata_d[WRITE_ENABLE_BIT] = wr_en_q;
      end else if (bus.sfr_rd && bus.sfr_addr == PAGE_SELECT_ADDR) begin
         rdata_d = page_sel_q;
      end else if (bus.x_rd && bus.x_addr == SECURITY_STATUS_ADDR) begin
         rdata_d[PIN_BIT]    = protect_lock_bit_pin;
         rdata_d[LEVEL0_BIT] = level0_q;
         rdata_d[LEVEL1_BIT] = level1_q;
      end
   end

   always_ff @(posedge clk) begin
      level0_q <= level0_d;
      level1_q <= level1_d;
      if (reset) begin
         lock_q     <= 1'b0;
         wr_en_q    <= 1'b0;
         mass_arm_q <= 1'b0;
         page_sel_q <= RESET_BYTE;
         rdata_q    <= RESET_BYTE;
      end else begin
         lock_q     <= lock_d;
         wr_en_q    <= wr_en_d;
         mass_arm_q <= mass_arm_d;
         page_sel_q <= page_sel_d;
         rdata_q    <= rdata_d;
      end
   end

   // ---------------- flash operations ----------------
   logic        dbg_en_d, grant_d, refuse_d;
   logic        mass_d, page_d, fwr_d, cref_d;
   logic [6:0]  page_num_d;
   logic [15:0] fwr_addr_d;
   logic [7:0]  fwr_data_d;

   always_comb begin
      dbg_en_d   = !level1_d;
      grant_d    = 1'b0;
      refuse_d   = 1'b0;
      mass_d     = 1'b0;
      page_d     = 1'b0;
      fwr_d      = 1'b0;
      cref_d     = 1'b0;
      page_num_d = erase_page_q;
      fwr_addr_d = flash_wr_addr_q;
      fwr_data_d = flash_wr_data_q;
      // processor erase commands
      if (erase_wr && bus.wdata == MASS_PATTERN) begin
         if (mass_arm_q && dbg_port_enable_q)
            mass_d = 1'b1;
         else
            cref_d = 1'b1;
      end else if (erase_wr && bus.wdata == PAGE_PATTERN) begin
         page_num_d = page_sel_q[7:1];
         if (protect && page_sel_q[7:1] == '0)
            cref_d = 1'b1;
         else
            page_d = 1'b1;
      end
      // processor stores into flash
      if (x_flash_wr) begin
         if (protect && is_page0(bus.x_addr)) begin
            cref_d = 1'b1;
         end else begin
            fwr_d      = 1'b1;
            fwr_addr_d = bus.x_addr;
            fwr_data_d = bus.wdata;
         end
      end
      // debug port requests
      if (dbg.valid) begin
         if (!dbg_port_enable_q) begin
            refuse_d = 1'b1;
         end else if (protect) begin
            // only bulk erase passes; reads of code and RAM are shut
            if (dbg.op == DBG_MASS_ERASE) begin
               grant_d = 1'b1;
               mass_d  = 1'b1;
            end else begin
               refuse_d = 1'b1;
            end
         end else begin
            grant_d = 1'b1;
            if (dbg.op == DBG_MASS_ERASE)
               mass_d = 1'b1;
            if (dbg.op == DBG_PAGE_ERASE) begin
               page_d     = 1'b1;
               page_num_d = dbg.addr[PAGE_LSB +: PAGE_WIDTH];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dbg_port_enable_q <= 1'b0;
         dbg_grant_q       <= 1'b0;
         dbg_refuse_q      <= 1'b0;
         mass_erase_q      <= 1'b0;
         xram_clear_q      <= 1'b0;
         page_erase_q      <= 1'b0;
         erase_page_q      <= '0;
         flash_wr_q        <= 1'b0;
         flash_wr_addr_q   <= '0;
         flash_wr_data_q   <= RESET_BYTE;
         cpu_refuse_q      <= 1'b0;
      end else begin
         dbg_port_enable_q <= dbg_en_d;
         dbg_grant_q       <= grant_d;
         dbg_refuse_q      <= refuse_d;
         mass_erase_q      <= mass_d;
         // the RAM wipe follows every global erase, locked or not
         xram_clear_q      <= mass_d;
         page_erase_q      <= page_d;
         erase_page_q      <= page_num_d;
         flash_wr_q        <= fwr_d;
         flash_wr_addr_q   <= fwr_addr_d;
         flash_wr_data_q   <= fwr_data_d;
         cpu_refuse_q      <= cref_d;
      end
   end

   fuse_burn_seq u_burn (
      .clk           (clk),
      .reset         (reset),
      .select_wr     (sel_wr),
      .trigger_wr    (trig_wr),
      .wdata         (bus.wdata),
      .protect_lock_bit_pin    (protect_lock_bit_pin),
      .burn_level0_q (burn_level0_q),
      .burn_level1_q (burn_level1_q)
   );

   // ---------------- checks ----------------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   property p_lock_sticky;
      lock_q |=> lock_q;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky)
      else $error("lock bit cleared without reset");

   property p_lock_set;
      ctl_wr && bus.wdata[LOCK_BIT] |=> lock_q;
   endproperty
   a_lock_set: assert property (p_lock_set)
      else $error("lock bit not set by write");

   property p_dbg_only_erase;
      dbg.valid && protect && dbg_port_enable_q && dbg.op != DBG_MASS_ERASE
         |=> dbg_refuse_q && !dbg_grant_q;
   endproperty
   a_dbg_only_erase: assert property (p_dbg_only_erase)
      else $error("debug operation passed while locked");

   property p_no_lock_effect;
      !level0_q && dbg.valid && dbg_port_enable_q |=> dbg_grant_q;
   endproperty
   a_no_lock_effect: assert property (p_no_lock_effect)
      else $error("lock acted without level0 fuse");

   property p_page0_write;
      x_flash_wr && protect && is_page0(bus.x_addr)
         |=> !flash_wr_q && cpu_refuse_q;
   endproperty
   a_page0_write: assert property (p_page0_write)
      else $error("page zero write went through");

   property p_page0_erase;
      page_erase_q && protect |-> erase_page_q != '0;
   endproperty
   a_page0_erase: assert property (p_page0_erase)
      else $error("page zero erased while locked");

   property p_ram_wipe;
      mass_erase_q |-> xram_clear_q;
   endproperty
   a_ram_wipe: assert property (p_ram_wipe)
      else $error("global erase without RAM wipe");

   property p_level1_off;
      level1_q |=> !dbg_port_enable_q && !dbg_grant_q;
   endproperty
   a_level1_off: assert property (p_level1_off)
      else $error("debug port alive with level1 fuse");

   property p_fuse_kept;
      level0_q ##1 1'b1 |-> level0_q;
   endproperty
   a_fuse_kept: assert property (p_fuse_kept)
      else $error("level0 fuse state lost");

   property p_mass_gate;
      mass_erase_q && !$past(dbg.valid) |-> $past(mass_arm_q)
         && $past(dbg_port_enable_q);
   endproperty
   a_mass_gate: assert property (p_mass_gate)
      else $error("mass erase without arm or debug port");

   property p_pin_status;
      bus.x_rd && bus.x_addr == SECURITY_STATUS_ADDR
         |=> rdata_q[PIN_BIT] == $past(protect_lock_bit_pin);
   endproperty
   a_pin_status: assert property (p_pin_status)
      else $error("pin status bit wrong");

   property p_lock_after_reset;
      $fell(reset) |-> !lock_q;
   endproperty
   a_lock_after_reset: assert property (p_lock_after_reset)
      else $error("lock bit survived a reset");

   property p_port_after_reset;
      $fell(reset) |=> dbg_port_enable_q == !level1_q;
   endproperty
   a_port_after_reset: assert property (p_port_after_reset)
      else $error("debug port state disagrees with level1 fuse");

   property p_dbg_read_shut;
      dbg.valid && protect && dbg.op == DBG_READ
         |=> dbg_refuse_q && !dbg_grant_q;
   endproperty
   a_dbg_read_shut: assert property (p_dbg_read_shut)
      else $error("debug read passed while locked");

   property p_ctl_read;
      bus.sfr_rd && bus.sfr_addr == FLASH_CONTROL_ADDR
         |=> rdata_q[LOCK_BIT] == $past(lock_q);
   endproperty
   a_ctl_read: assert property (p_ctl_read)
      else $error("lock bit misread");

   property p_status_fuses;
      bus.x_rd && bus.x_addr == SECURITY_STATUS_ADDR
         |=> rdata_q[LEVEL0_BIT] == $past(level0_q)
             && rdata_q[LEVEL1_BIT] == $past(level1_q);
   endproperty
   a_status_fuses: assert property (p_status_fuses)
      else $error("fuse status bits wrong");

   property p_mass_needs_port;
      erase_wr && bus.wdata == MASS_PATTERN && !dbg_port_enable_q
         |=> cpu_refuse_q && !mass_erase_q;
   endproperty
   a_mass_needs_port: assert property (p_mass_needs_port)
      else $error("mass erase ran with debug port off");

   property p_page0_refuse;
      erase_wr && bus.wdata == PAGE_PATTERN && protect
         && page_sel_q[7:1] == '0 |=> cpu_refuse_q && !page_erase_q;
   endproperty
   a_page0_refuse: assert property (p_page0_refuse)
      else $error("page zero erase not refused");

   property p_dbg_mass;
      dbg.valid && dbg_port_enable_q && dbg.op == DBG_MASS_ERASE
         |=> mass_erase_q && xram_clear_q;
   endproperty
   a_dbg_mass: assert property (p_dbg_mass)
      else $error("debug bulk erase without RAM wipe");
endmodule

/* File: sim/debug_host_model.sv */
`timescale 1ns/100ps
module debug_host_model
   import fuse_ctl_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 go,
   input  fuse_ctl_pkg::dbg_op_type  op,
   input  wire logic [15:0]          addr,
   output fuse_ctl_pkg::dbg_req_type dbg
);
   // one request per go pulse; between requests the host scrambles
   // the released op and address so stale values never look valid
   always @(posedge clk) begin
      if (go) begin
         dbg.valid <= 1'h1;
         dbg.op    <= op;
         dbg.addr  <= addr;
      end else begin
         dbg.valid <= 1'h0;
         dbg.op    <= dbg_op_type'(~dbg.op);
         dbg.addr  <= ~dbg.addr;
      end
   end
endmodule

/* File: sim/program_security_fuse_control_tb.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin \
   checks++; \
   if ((a) !== (e)) begin \
      n_fail++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); \
   end \
end
module program_security_fuse_control_tb;
   import fuse_ctl_pkg::*;
   typedef struct packed {
      logic [2:0]  kind;
      logic [15:0] addr;
      logic [7:0]  d;
      logic [7:0]  rd;
      logic [6:0]  ev;
   } row_type;

   logic        clk;
   logic        reset;
   bus_req_type bus;
   logic        irq_enabled;
   logic        fuse0;
   logic        fuse1;
   logic        protect_lock_bit_pin;
   logic        host_go;
   dbg_op_type  host_op;
   logic [15:0] host_addr;
   dbg_req_type dbg;
   logic [7:0]  rdata_q;
   logic        dbg_port_enable_q;
   logic        dbg_grant_q;
   logic        dbg_refuse_q;
   logic        mass_erase_q;
   logic        xram_clear_q;
   logic        page_erase_q;
   logic [6:0]  erase_page_q;
   logic        flash_wr_q;
   logic [15:0] flash_wr_addr_q;
   logic [7:0]  flash_wr_data_q;
   logic        cpu_refuse_q;
   logic        burn_level0_q;
   logic        burn_level1_q;
   logic [6:0]  ev;
   int          n_fail;
   int          checks;

   // kind bits: sfr space, write, protect_lock_bit pin level
   row_type rows [31] = '{
      '{3'h4,16'h00b2,8'h00,8'h00,7'h00},
      '{3'h0,16'hffd7,8'h00,8'h00,7'h00},
      '{3'h6,16'h00b2,8'h40,8'h00,7'h00},
      '{3'h4,16'h00b2,8'h00,8'h40,7'h00},
      '{3'h6,16'h00b2,8'h00,8'h00,7'h00},
      '{3'h4,16'h00b2,8'h00,8'h40,7'h00},
      '{3'h6,16'h00b7,8'h00,8'h00,7'h00},
      '{3'h6,16'h0094,8'h55,8'h00,7'h10},
      '{3'h6,16'h00b2,8'h01,8'h00,7'h00},
      '{3'h2,16'h0010,8'h5a,8'h00,7'h08},
      '{3'h0,16'h1234,8'h00,8'h00,7'h00},
      '{3'h2,16'hffd1,8'ha6,8'h00,7'h00},
      '{3'h2,16'hffd2,8'h54,8'h00,7'h00},
      '{3'h2,16'hffd2,8'h81,8'h00,7'h00},
      '{3'h2,16'hffd1,8'ha6,8'h00,7'h02},
      '{3'h2,16'hffd1,8'h00,8'h00,7'h00},
      '{3'h2,16'hffd2,8'h54,8'h00,7'h00},
      '{3'h2,16'hffd2,8'h82,8'h00,7'h00},
      '{3'h2,16'hffd1,8'ha6,8'h00,7'h00},
      '{3'h1,16'hffd7,8'h00,8'h20,7'h00},
      '{3'h3,16'hffd2,8'h54,8'h00,7'h00},
      '{3'h3,16'hffd2,8'h82,8'h00,7'h00},
      '{3'h3,16'hffd1,8'ha6,8'h00,7'h01},
      '{3'h3,16'hffd1,8'h55,8'h00,7'h00},
      '{3'h6,16'h00b2,8'h02,8'h00,7'h00},
      '{3'h6,16'h0094,8'haa,8'h00,7'h60},
      '{3'h6,16'h0094,8'haa,8'h00,7'h04},
      '{3'h3,16'hffd2,8'h54,8'h00,7'h00},
      '{3'h3,16'hffd2,8'h82,8'h00,7'h00},
      '{3'h3,16'hffd1,8'ha6,8'h00,7'h01},
      '{3'h0,16'h1234,8'h00,8'h00,7'h00}
   };

   assign ev = {mass_erase_q, xram_clear_q, page_erase_q, flash_wr_q,
                cpu_refuse_q, burn_level0_q, burn_level1_q};

   program_security_fuse_control DUT (
      .clk               (clk),
      .reset             (reset),
      .bus               (bus),
      .irq_enabled       (irq_enabled),
      .level0_fuse_raw   (fuse0),
      .level1_fuse_raw   (fuse1),
      .protect_lock_bit_pin        (protect_lock_bit_pin),
      .dbg               (dbg),
      .rdata_q           (rdata_q),
      .dbg_port_enable_q (dbg_port_enable_q),
      .dbg_grant_q       (dbg_grant_q),
      .dbg_refuse_q      (dbg_refuse_q),
      .mass_erase_q      (mass_erase_q),
      .xram_clear_q      (xram_clear_q),
      .page_erase_q      (page_erase_q),
      .erase_page_q      (erase_page_q),
      .flash_wr_q        (flash_wr_q),
      .flash_wr_addr_q   (flash_wr_addr_q),
      .flash_wr_data_q   (flash_wr_data_q),
      .cpu_refuse_q      (cpu_refuse_q),
      .burn_level0_q     (burn_level0_q),
      .burn_level1_q     (burn_level1_q)
   );

   debug_host_model host (
      .clk  (clk),
      .go   (host_go),
      .op   (host_op),
      .addr (host_addr),
      .dbg  (dbg)
   );

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic print_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // one strobe cycle, then sample the registered answer mid-cycle
   task automatic bus_op(input logic [2:0] k, input logic [15:0] a,
                         input logic [7:0] d);
      @(posedge clk);
      protect_lock_bit_pin   <= k[0];
      bus.sfr_wr   <= k[2] & k[1];
      bus.sfr_rd   <= k[2] & ~k[1];
      bus.x_wr     <= ~k[2] & k[1];
      bus.x_rd     <= ~k[2] & ~k[1];
      bus.sfr_addr <= a[7:0];
      bus.x_addr   <= a;
      bus.wdata    <= d;
      @(posedge clk);
      bus <= '0;
      @(negedge clk);
   endtask

   task automatic dbg_do(input dbg_op_type op, input logic [15:0] a);
      @(posedge clk);
      host_go   <= 1'h1;
      host_op   <= op;
      host_addr <= a;
      @(posedge clk);
      host_go <= 1'h0;
      @(posedge clk);
      @(negedge clk);
   endtask

   // fuses are loaded fresh only while reset is held; outside reset a raw high still sets them
   task automatic do_reset;
      @(posedge clk);
      reset <= 1'h1;
      repeat (10) @(posedge clk);
      reset <= 1'h0;
      // let the release edge load the fuse-derived state
      @(posedge clk);
      @(negedge clk);
   endtask

   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      print_verdict();
   end

   initial begin
      n_fail = 0;
      checks = 0;
      reset = 1'h1;
      bus = '0;
      irq_enabled = 1'h0;
      fuse0 = 1'h0;
      fuse1 = 1'h0;
      protect_lock_bit_pin = 1'h0;
      host_go = 1'h0;
      host_op = DBG_READ;
      host_addr = 16'h0000;
      repeat (10) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      @(negedge clk);
      `CHK(dbg_port_enable_q, 1'h1)
      foreach (rows[i]) begin
         bus_op(rows[i].kind, rows[i].addr, rows[i].d);
         `CHK(rdata_q, rows[i].rd)
         `CHK(ev, rows[i].ev)
      end
      dbg_do(DBG_READ, 16'h0000);
      `CHK({dbg_grant_q, dbg_refuse_q}, 2'h2)
      $display("test table done");

      fuse0 <= 1'h1;
      do_reset();
      bus_op(3'h0, 16'hffd7, 8'h00);
      `CHK(rdata_q, 8'h02)
      bus_op(3'h6, 16'h00b2, 8'h40);
      dbg_do(DBG_READ, 16'h0100);
      `CHK({dbg_grant_q, dbg_refuse_q}, 2'h1)
      dbg_do(DBG_PAGE_ERASE, 16'h0000);
      `CHK({dbg_grant_q, dbg_refuse_q}, 2'h1)
      dbg_do(DBG_WRITE, 16'h0004);
      `CHK({dbg_grant_q, dbg_refuse_q}, 2'h1)
      bus_op(3'h6, 16'h00b7, 8'h00);
      bus_op(3'h6, 16'h0094, 8'h55);
      `CHK(ev, 7'h04)
      bus_op(3'h6, 16'h00b7, 8'h02);
      bus_op(3'h6, 16'h0094, 8'h55);
      `CHK({ev, erase_page_q}, {7'h10, 7'h01})
      bus_op(3'h6, 16'h00b2, 8'h01);
      bus_op(3'h2, 16'h01ff, 8'h3c);
      `CHK(ev, 7'h04)
      bus_op(3'h6, 16'h00b2, 8'h01);
      bus_op(3'h2, 16'h0200, 8'h3c);
      `CHK({ev, flash_wr_addr_q, flash_wr_data_q}, {7'h08, 24'h02003c})
      fuse0 <= 1'h0;
      bus_op(3'h0, 16'hffd7, 8'h00);
      `CHK(rdata_q, 8'h02)
      dbg_do(DBG_MASS_ERASE, 16'h0000);
      `CHK({dbg_grant_q, mass_erase_q, xram_clear_q}, 3'h7)
      fuse0 <= 1'h1;
      do_reset();
      dbg_do(DBG_READ, 16'h0100);
      `CHK({dbg_grant_q, dbg_refuse_q}, 2'h2)
      $display("test level zero done");

      irq_enabled <= 1'h1;
      bus_op(3'h6, 16'h00b2, 8'h01);
      bus_op(3'h4, 16'h00b2, 8'h00);
      `CHK(rdata_q, 8'h00)
      irq_enabled <= 1'h0;
      $display("test interrupt gate done");

      fuse1 <= 1'h1;
      do_reset();
      `CHK(dbg_port_enable_q, 1'h0)
      bus_op(3'h0, 16'hffd7, 8'h00);
      `CHK(rdata_q, 8'h03)
      dbg_do(DBG_MASS_ERASE, 16'h0000);
      `CHK({dbg_grant_q, dbg_refuse_q}, 2'h1)
      bus_op(3'h6, 16'h00b2, 8'h02);
      bus_op(3'h6, 16'h0094, 8'haa);
      `CHK(ev, 7'h04)
      fuse1 <= 1'h0;
      bus_op(3'h0, 16'hffd7, 8'h00);
      `CHK({rdata_q, dbg_port_enable_q}, {8'h03, 1'h0})
      $display("test level one done");
      print_verdict();
   end
endmodule
